// file: design/ssee_slave.v
// Purpose: Two-wire serial slave of a 256 x 8 EEPROM.
// Assumes: CORE_CLK_I far faster than SCL; SDA is open drain with pull-up.
// Notes: Array is not reset; it stands for nonvolatile cells.
`timescale 1ns/1ps
`default_nettype none
`include "ssee_regs.vh"
module ssee_slave #(
	parameter [3:0] DEV_TYPE = 4'ha // Fixed upper address bits, arbitrary default
) (
	// Clock and reset
	input  wire CORE_CLK_I,
	input  wire RST_N_I,
	// Serial bus
	input  wire SCL_I,
	input  wire SDA_I,
	output wire SDA_O,
	output wire SDA_OE_O,
	// Chip select straps
	input  wire CHIP_SELECT_PIN_BIT0_I,
	input  wire CHIP_SELECT_PIN_BIT1_I,
	input  wire CHIP_SELECT_PIN_BIT2_I,
	// Program timing network
	input  wire PROGRAM_TIMING_NETWORK_INPUT_I,
	output wire PROGRAM_NET_CHARGE_O,
	output wire PROGRAM_BUSY_O
);
	localparam ST_IDLE  = 3'h0;
	localparam ST_ADDR  = 3'h1;
	localparam ST_WADDR = 3'h2;
	localparam ST_WDATA = 3'h3;
	localparam ST_ACK   = 3'h4;
	localparam ST_RDATA = 3'h5;
	localparam ST_RACK  = 3'h6;
	localparam ST_IGN   = 3'h7;

	// Wrapping pointer step
	function [7:0] ptr_inc;
		input [7:0] p;
		begin
			ptr_inc = p + 8'h01;
		end
	endfunction

	reg  [5:0] sync1_q;
	reg  [5:0] sync2_q;
	reg        scl_prev_q;
	reg        sda_prev_q;
	reg  [2:0] state_q;
	reg  [2:0] next_q;
	reg  [3:0] bit_cnt_q;
	reg  [7:0] shift_q;
	reg  [7:0] tx_q;
	reg  [7:0] ptr_q;
	reg  [1:0] wcnt_q;
	reg  [7:0] wr_addr_q [0:1];
	reg  [7:0] wr_data_q [0:1];
	reg        sda_oe_q;
	reg        mack_q;
	reg        prog_start_q;
	reg  [7:0] mem [0:255];

	wire       scl      = sync2_q[0];
	wire       sda      = sync2_q[1];
	wire [2:0] cs_pins  = sync2_q[4:2];
	wire       net      = sync2_q[5];
	wire       scl_rise = scl & ~scl_prev_q;
	wire       scl_fall = ~scl & scl_prev_q;
	wire       start_ev = scl & scl_prev_q & sda_prev_q & ~sda;
	wire       stop_ev  = scl & scl_prev_q & ~sda_prev_q & sda;
	wire       busy;
	wire       byte_done;
	wire       byte_idx;
	wire [7:0] rd_byte  = mem[ptr_q];
	wire       addr_hit = (shift_q[`SSEE_TYPE_MSB:`SSEE_TYPE_LSB] == DEV_TYPE) &&
	                      (shift_q[`SSEE_CS_MSB:`SSEE_CS_LSB] == cs_pins);

	// Open drain: only ever pull low
	assign SDA_O          = 1'b0;
	assign SDA_OE_O       = sda_oe_q;
	assign PROGRAM_BUSY_O = busy;

	// Every bus, strap and network pin passes two flops; edges come from the second stage only
	always @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			sync1_q    <= 6'h03;
			sync2_q    <= 6'h03;
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			sync1_q    <= {PROGRAM_TIMING_NETWORK_INPUT_I, CHIP_SELECT_PIN_BIT2_I,
			               CHIP_SELECT_PIN_BIT1_I, CHIP_SELECT_PIN_BIT0_I, SDA_I, SCL_I};
			sync2_q    <= sync1_q;
			scl_prev_q <= scl;
			sda_prev_q <= sda;
		end
	end

	// Protocol engine; SCL is only sampled, so it must run far slower than CORE_CLK_I
	always @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_q      <= ST_IDLE;
			next_q       <= ST_IDLE;
			bit_cnt_q    <= 4'h0;
			shift_q      <= 8'h00;
			tx_q         <= 8'h00;
			ptr_q        <= `SSEE_PTR_RESET;
			wcnt_q       <= 2'h0;
			wr_addr_q[0] <= 8'h00;
			wr_addr_q[1] <= 8'h00;
			wr_data_q[0] <= 8'h00;
			wr_data_q[1] <= 8'h00;
			sda_oe_q     <= 1'b0;
			mack_q       <= 1'b0;
			prog_start_q <= 1'b0;
		end else begin
			prog_start_q <= 1'b0;
			if (prog_start_q)
				wcnt_q <= 2'h0;
			if (start_ev) begin
				// Repeated start drops any unfinished write bytes
				state_q   <= ST_ADDR;
				bit_cnt_q <= 4'h0;
				sda_oe_q  <= 1'b0;
				wcnt_q    <= 2'h0;
			end else if (stop_ev) begin
				state_q  <= ST_IDLE;
				sda_oe_q <= 1'b0;
				// Count kept until the timer has latched it
				if (wcnt_q != 2'h0 && !busy)
					prog_start_q <= 1'b1;
				else
					wcnt_q <= 2'h0;
			end else if (scl_rise) begin
				// Data is taken while SCL is high
				case (state_q)
					ST_ADDR, ST_WADDR, ST_WDATA: begin
						shift_q   <= {shift_q[6:0], sda};
						bit_cnt_q <= bit_cnt_q + 4'h1;
					end
					ST_RDATA: bit_cnt_q <= bit_cnt_q + 4'h1;
					ST_RACK: begin
						mack_q <= ~sda;
						if (!sda)
							ptr_q <= ptr_inc(ptr_q);
					end
					default: ;
				endcase
			end else if (scl_fall) begin
				// Outputs change only after SCL has fallen
				case (state_q)
					ST_ADDR: begin
						if (bit_cnt_q == `SSEE_BYTE_BITS) begin
							if (addr_hit && !busy) begin
								sda_oe_q <= 1'b1;
								next_q   <= shift_q[`SSEE_RW_BIT] ? ST_RDATA : ST_WADDR;
								state_q  <= ST_ACK;
							end else begin
								state_q <= ST_IGN;
							end
						end
					end
					ST_WADDR: begin
						if (bit_cnt_q == `SSEE_BYTE_BITS) begin
							ptr_q    <= shift_q;
							sda_oe_q <= 1'b1;
							next_q   <= ST_WDATA;
							state_q  <= ST_ACK;
						end
					end
					ST_WDATA: begin
						if (bit_cnt_q == `SSEE_BYTE_BITS) begin
							if (wcnt_q < `SSEE_MAX_WR_BYTES) begin
								wr_addr_q[wcnt_q[0]] <= ptr_q;
								wr_data_q[wcnt_q[0]] <= shift_q;
								ptr_q    <= ptr_inc(ptr_q);
								wcnt_q   <= wcnt_q + 2'h1;
								sda_oe_q <= 1'b1;
								next_q   <= ST_WDATA;
								state_q  <= ST_ACK;
							end else begin
								// A third byte is refused and not stored
								state_q <= ST_IGN;
							end
						end
					end
					ST_ACK: begin
						// Low was held across the whole ninth pulse
						bit_cnt_q <= 4'h0;
						if (next_q == ST_RDATA) begin
							tx_q     <= rd_byte;
							sda_oe_q <= ~rd_byte[7];
						end else begin
							sda_oe_q <= 1'b0;
						end
						state_q <= next_q;
					end
					ST_RDATA: begin
						if (bit_cnt_q == `SSEE_BYTE_BITS) begin
							sda_oe_q <= 1'b0;
							state_q  <= ST_RACK;
						end else begin
							tx_q     <= {tx_q[6:0], 1'b0};
							sda_oe_q <= ~tx_q[6];
						end
					end
					ST_RACK: begin
						if (mack_q) begin
							// Unlimited streaming while the master acknowledges
							tx_q      <= rd_byte;
							sda_oe_q  <= ~rd_byte[7];
							bit_cnt_q <= 4'h0;
							state_q   <= ST_RDATA;
						end else begin
							sda_oe_q <= 1'b0;
							state_q  <= ST_IGN;
						end
					end
					default: sda_oe_q <= 1'b0;
				endcase
			end
		end
	end

	// Cells written one at a time as each RC period ends
	always @(posedge CORE_CLK_I) begin
		if (byte_done)
			mem[wr_addr_q[byte_idx]] <= wr_data_q[byte_idx];
	end

	ssee_prog_timer u_timer (
		.clk_i       (CORE_CLK_I),
		.rst_n_i     (RST_N_I),
		.start_i     (prog_start_q),
		.count_i     (wcnt_q),
		.net_i       (net),
		.charge_o    (PROGRAM_NET_CHARGE_O),
		.busy_o      (busy),
		.byte_done_o (byte_done),
		.byte_idx_o  (byte_idx)
	);
endmodule // ssee_slave
`default_nettype wire

// file: design/ssee_regs.vh
// Purpose: Constants for the two-wire serial EEPROM slave.
// Assumes: Included by bare name from the slave design file.
// Notes: Offsets and field positions of the serial byte frames.
`ifndef SSEE_REGS_VH
`define SSEE_REGS_VH
`define SSEE_BYTE_BITS     4'h8
`define SSEE_RW_BIT        0
`define SSEE_CS_LSB        1
`define SSEE_CS_MSB        3
`define SSEE_TYPE_LSB      4
`define SSEE_TYPE_MSB      7
`define SSEE_MAX_WR_BYTES  2'h2
`define SSEE_PTR_RESET     8'h00
`endif

// file: design/ssee_prog_timer.v
// Purpose: Sequences the nonvolatile program cycle from an RC network.
// Assumes: net_i already synchronised; high once the capacitor has charged.
// Notes: One full discharge/charge period per byte programmed.
`timescale 1ns/1ps
`default_nettype none
module ssee_prog_timer (
	// Clock and reset
	input  wire       clk_i,
	input  wire       rst_n_i,
	// Control
	input  wire       start_i,
	input  wire [1:0] count_i,
	input  wire       net_i,
	// Status
	output reg        charge_o,
	output wire       busy_o,
	output reg        byte_done_o,
	output reg        byte_idx_o
);
	localparam ST_IDLE   = 2'h0;
	localparam ST_DISCH  = 2'h1;
	localparam ST_CHARGE = 2'h2;

	reg [1:0] state_q;
	reg [1:0] count_q;

	assign busy_o = (state_q != ST_IDLE);

	// Time comes only from the RC network, never from SCL
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q     <= ST_IDLE;
			count_q     <= 2'h0;
			charge_o    <= 1'b0;
			byte_done_o <= 1'b0;
			byte_idx_o  <= 1'b0;
		end else begin
			byte_done_o <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					charge_o <= 1'b0;
					if (start_i) begin
						count_q    <= count_i;
						byte_idx_o <= 1'b0;
						state_q    <= ST_DISCH;
					end
				end
				ST_DISCH: begin
					// Index steps only after the first cell write has used it
					if (byte_done_o)
						byte_idx_o <= 1'b1;
					// Start every period from an empty capacitor
					if (!net_i) begin
						charge_o <= 1'b1;
						state_q  <= ST_CHARGE;
					end
				end
				ST_CHARGE: begin
					if (net_i) begin
						charge_o    <= 1'b0;
						byte_done_o <= 1'b1;
						if (count_q == 2'h2 && !byte_idx_o) begin
							state_q <= ST_DISCH;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end
endmodule // ssee_prog_timer
`default_nettype wire

// file: test/ssee_monitor.sv
// Purpose: Port-level checks of the serial EEPROM slave.
// Assumes: Bus bits last 8 core clocks or more.
// Notes: Bound to every ssee_slave instance.
`timescale 1ns/1ps
`default_nettype none
module ssee_monitor (
	// Clock and reset
	input  wire logic CORE_CLK_I,
	input  wire logic RST_N_I,
	// Bus and program network
	input  wire logic SCL_I,
	input  wire logic SDA_I,
	input  wire logic SDA_O,
	input  wire logic SDA_OE_O,
	input  wire logic PROGRAM_TIMING_NETWORK_INPUT_I,
	input  wire logic PROGRAM_NET_CHARGE_O,
	input  wire logic PROGRAM_BUSY_O
);
	default clocking @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	a_drive_only_low: assert property (SDA_O == 1'b0)
		else $error("data pin not low");
	a_move_scl_low: assert property ($changed(SDA_OE_O) |-> !SCL_I && !$past(SCL_I, 2))
		else $error("data moved with clock high");
	a_busy_no_ack: assert property ($rose(SDA_OE_O) |-> !PROGRAM_BUSY_O)
		else $error("acknowledge while busy");
	a_charge_in_busy: assert property (PROGRAM_NET_CHARGE_O |-> PROGRAM_BUSY_O)
		else $error("charge outside program cycle");
	a_busy_after_stop: assert property ($rose(PROGRAM_BUSY_O) |-> $past(SCL_I, 4) && $past(SDA_I, 4)
		&& !$past(SDA_I, 5))
		else $error("program began without stop");
	a_charge_end_net: assert property ($fell(PROGRAM_NET_CHARGE_O) |-> PROGRAM_TIMING_NETWORK_INPUT_I)
		else $error("charge ended before network");
	a_charge_holds: assert property (PROGRAM_NET_CHARGE_O && !PROGRAM_TIMING_NETWORK_INPUT_I
		|=> PROGRAM_NET_CHARGE_O)
		else $error("charge dropped early");
	a_busy_end: assert property ($fell(PROGRAM_BUSY_O) |-> $fell(PROGRAM_NET_CHARGE_O))
		else $error("busy end not after last period");
endmodule // ssee_monitor
bind ssee_slave ssee_monitor u_ssee_monitor (.CORE_CLK_I(CORE_CLK_I), .RST_N_I(RST_N_I),
	.SCL_I(SCL_I), .SDA_I(SDA_I), .SDA_O(SDA_O), .SDA_OE_O(SDA_OE_O),
	.PROGRAM_TIMING_NETWORK_INPUT_I(PROGRAM_TIMING_NETWORK_INPUT_I),
	.PROGRAM_NET_CHARGE_O(PROGRAM_NET_CHARGE_O), .PROGRAM_BUSY_O(PROGRAM_BUSY_O));
`default_nettype wire

// file: test/ssee_master_model.sv
// Purpose: Two-wire bus master.
// Assumes: SDA wire resolved with a pull-up outside.
// Notes: A bit is 5 clocks low, 3 high: 160 ns.
`timescale 1ns/1ps
`default_nettype none
module ssee_master_model (
	input  wire logic clk_i,
	input  wire logic sda_i,
	output var  logic scl_o,
	output var  logic oe_o
);
	initial begin
		scl_o = 1'b1; // Idle bus
		oe_o = 1'b0;
	end
	task automatic q(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// Start when rise is 0, stop when 1
	task automatic cond(input logic rise);
		scl_o <= 1'b0;
		q(2);
		oe_o <= rise;
		q(3);
		scl_o <= 1'b1;
		q(4);
		oe_o <= ~rise;
		q(4);
	endtask
	// Clock parked low so the slave acts on the last fall
	task automatic park(input int n);
		scl_o <= 1'b0;
		q(n);
	endtask
	// Data changes only while clock low
	task automatic bit1(input logic b, output logic r);
		scl_o <= 1'b0;
		q(1);
		oe_o <= ~b;
		q(4);
		scl_o <= 1'b1;
		q(2);
		r = sda_i;
		q(1);
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit1(d[i], r);
		bit1(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bit1(1'b1, d[i]);
		bit1(last, r);
	endtask
endmodule // ssee_master_model
`default_nettype wire

// file: test/ssee_slave_test.sv
// Purpose: Self-checking bench of the serial EEPROM slave.
// Assumes: RC network modelled as 200 clocks of charge.
// Notes: Chip select straps at 3'h5.
`timescale 1ns/1ps
`default_nettype none
module ssee_slave_test;
	localparam logic [3:0] DT = 4'ha; // Arbitrary type code
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic       net = 1'b0;
	logic [2:0] cs = 3'h5;
	int         cnt = 0;
	int         periods = 0;
	int         err_count = 0;
	int         samples_checked = 0;
	wire        scl, moe, oe, sdo, chg, busy;
	wire        sda = ~moe & (oe ? sdo : 1'b1); // Pull-up when nobody drives
	always #10 clk = ~clk;
	always @(posedge clk) begin
		cnt <= chg ? cnt + 1 : 0;
		net <= chg && cnt >= 200;
	end
	always @(posedge chg) periods++;
	ssee_slave #(.DEV_TYPE(DT)) u_ssee_slave (.CORE_CLK_I(clk), .RST_N_I(rst_n), .SCL_I(scl), .SDA_I(sda),
		.SDA_O(sdo), .SDA_OE_O(oe), .CHIP_SELECT_PIN_BIT0_I(cs[0]), .CHIP_SELECT_PIN_BIT1_I(cs[1]),
		.CHIP_SELECT_PIN_BIT2_I(cs[2]), .PROGRAM_TIMING_NETWORK_INPUT_I(net),
		.PROGRAM_NET_CHARGE_O(chg), .PROGRAM_BUSY_O(busy));
	ssee_master_model u_ssee_master_model (.clk_i(clk), .sda_i(sda), .scl_o(scl), .oe_o(moe));
	task automatic test_done;
		$display("checked=%0d errors=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic st(input logic rise);
		u_ssee_master_model.cond(rise);
	endtask
	task automatic xfer(input logic [7:0] d, input logic ack);
		logic a;
		u_ssee_master_model.wbyte(d, a);
		chk({7'h0, a}, {7'h0, ack});
	endtask
	task automatic rd(input logic last, input logic [7:0] exp);
		logic [7:0] d;
		u_ssee_master_model.rbyte(last, d);
		chk(d, exp);
		if (last) begin
			// Release already shows from the fall after the eighth bit, before the nack
			u_ssee_master_model.park(6);
			chk({7'h0, oe}, 8'h0);
		end
	endtask
	task automatic wait_idle;
		int n;
		repeat (8) @(posedge clk);
		for (n = 0; n < 4000 && busy !== 1'b0; n++) @(posedge clk);
		if (n == 4000) begin
			err_count++;
			test_done();
		end
	endtask
	// Two bytes across the top address, busy refusal, reads back
	task automatic s_write_wrap;
		int p0;
		p0 = periods;
		st(0); xfer({DT, cs, 1'b0}, 1); xfer(8'hff, 1); xfer(8'h5a, 1); xfer(8'ha5, 1); st(1);
		st(0); xfer({DT, cs, 1'b1}, 0); st(1);
		wait_idle();
		chk(8'(periods - p0), 8'h2);
		st(0); xfer({DT, cs, 1'b0}, 1); xfer(8'hff, 1); st(0); xfer({DT, cs, 1'b1}, 1);
		rd(0, 8'h5a); rd(1, 8'ha5); st(1);
		st(0); xfer({DT, cs, 1'b1}, 1); rd(1, 8'ha5); st(1);
	endtask
	// Third data byte of a write is refused
	task automatic s_three;
		st(0); xfer({DT, cs, 1'b0}, 1); xfer(8'h10, 1); xfer(8'h11, 1); xfer(8'h22, 1); xfer(8'h33, 0); st(1);
		wait_idle();
		st(0); xfer({DT, cs, 1'b0}, 1); xfer(8'h10, 1); st(0); xfer({DT, cs, 1'b1}, 1);
		rd(0, 8'h11); rd(1, 8'h22); st(1);
	endtask
	// Other chip selects and type stay silent
	task automatic s_wrong_cs;
		for (int k = 1; k < 8; k++) begin
			st(0); xfer({DT, cs ^ 3'(k), 1'b0}, 0); xfer(8'h00, 0); st(1);
		end
		st(0); xfer({~DT, cs, 1'b1}, 0); st(1);
	endtask
	initial begin
		repeat (5) @(posedge clk);
		chk({5'h0, oe, chg, busy}, 8'h0);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		s_write_wrap();
		s_three();
		s_wrong_cs();
		test_done();
	end
endmodule // ssee_slave_test
`default_nettype wire
